/* hw/startup_status_pkg.sv */
// constants for the startup status register block
package startup_status_pkg;
   // register byte offsets
   localparam logic [5:0] OFS_DEVICE_STATUS = 6'h00;
   localparam logic [5:0] OFS_EVENT_STATUS = 6'h04;
   localparam logic [5:0] OFS_EVENT_MASK = 6'h08;
   localparam logic [5:0] OFS_OSC_CAL_TIMEOUT = 6'h0C;
   localparam logic [5:0] OFS_SELFTEST_CONFIG = 6'h10;
   localparam logic [5:0] OFS_LOCK_KEY = 6'h14;
   // device_status field positions
   localparam int POS_LOGIC_SELFTEST = 19;
   localparam int POS_BOOT_COMPLETE = 18;
   localparam int POS_TIMEOUT_LSB = 14;
   localparam int POS_ENGINE1 = 13;
   localparam int POS_ENGINE0 = 12;
   localparam int POS_ANALOG_SELFTEST = 11;
   localparam int POS_DIGITAL_SELFTEST = 10;
   localparam int POS_BACKUP_OSC = 9;
   localparam int POS_CRYSTAL = 8;
   localparam int POS_CONFIG_LOAD = 7;
   localparam int POS_WRITE_LOCKED = 6;
   localparam int POS_SINGLE_ENDED = 5;
   localparam int POS_USER_VALID = 4;
   // event_status / event_mask bit positions
   localparam int EV_BOOT = 0;
   localparam int EV_TIMEOUT_LSB = 1;
   localparam int EV_BACKUP_OSC = 5;
   localparam int EV_CONFIG_LOAD = 6;
   localparam int EV_LOGIC_SELFTEST = 7;
   localparam int EV_WIDTH = 8;
   // selftest_config bit positions
   localparam int POS_ANALOG_EN = 0;
   localparam int POS_DIGITAL_EN = 1;
   // reset values
   localparam logic [31:0] DEVICE_STATUS_RESET = 32'h0000_0000;
   localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
   localparam logic [15:0] OSC_CAL_TIMEOUT_RESET = 16'h03E8;
   localparam logic [1:0] SELFTEST_CONFIG_RESET = 2'h0;
   // lock key values, arbitrary
   localparam logic [15:0] LOCK_KEY_SET = 16'hA5C3;
   localparam logic [15:0] LOCK_KEY_CLEAR = 16'h5A3C;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int BIAS_TIMEOUT_MS = 2;
   localparam int CONFIG_TIMEOUT_MS = 15;
   localparam int PLL_TIMEOUT_MS = 2;
   localparam int BIAS_TIMEOUT_US = BIAS_TIMEOUT_MS * 1000;
   localparam int CONFIG_TIMEOUT_US = CONFIG_TIMEOUT_MS * 1000;
   localparam int PLL_TIMEOUT_US = PLL_TIMEOUT_MS * 1000;
   localparam int FALLBACK_WAIT_CYCLES = 1000;
   localparam int SYNC_FILL_CYCLES = 3;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/device_startup_status.sv */
// startup status word with AXI4-Lite access and event interrupt
`timescale 1ns/100ps
module device_startup_status
   import startup_status_pkg::*;
#(
   parameter int BIAS_LIMIT_US = BIAS_TIMEOUT_US,
   parameter int CONFIG_LIMIT_US = CONFIG_TIMEOUT_US,
   parameter int PLL_LIMIT_US = PLL_TIMEOUT_US
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // axi4-lite write address, data and response
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // startup sequencer
   input wire logic logic_selftest_done,
   input wire logic boot_sequence_done,
   input wire logic [3:0] phase_start,
   input wire logic [3:0] phase_done,
   input wire logic analog_selftest_done,
   input wire logic digital_selftest_done,
   input wire logic sysdiv_toggle,
   // clocking and spread engines
   input wire logic spread_engine0_active,
   input wire logic spread_engine1_active,
   input wire logic crystal_select,
   // configuration loader
   input wire logic common_config_done,
   input wire logic config_load_done,
   input wire logic single_ended_detect,
   input wire logic user_config_done,
   input wire logic user_config_ok,
   input wire logic [3:0] user_config_index,
   // outputs
   output logic ring_osc_select,
   output logic config_write_locked,
   output logic irq
);

   // bus state
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic aw_held_reg, w_held_reg;
   logic [5:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   // register state
   logic [31:0] status_reg;
   logic [EV_WIDTH-1:0] event_reg, mask_reg;
   logic [15:0] osc_cal_reg;
   logic [1:0] selftest_cfg_reg;
   logic locked_reg, common_done_reg, irq_reg;
   // timers
   logic [6:0] us_div_reg;
   logic us_tick_reg;
   logic [3:0] timer_run_reg;
   logic [23:0] timer_cnt_reg [4];
   logic [3:0] timeout_pulse;
   // fallback watch
   logic toggle_s1_reg, toggle_s2_reg, toggle_s3_reg;
   logic [15:0] fallback_cnt_reg;
   logic toggle_seen_reg, fallback_reg;
   // decode
   logic do_write, do_read;
   logic [31:0] rd_word;
   logic [1:0] rd_resp, wr_resp;
   logic [EV_WIDTH-1:0] ev_set;

   function automatic logic is_mapped(input logic [5:0] a);
      is_mapped = (a == OFS_DEVICE_STATUS) || (a == OFS_EVENT_STATUS) ||
         (a == OFS_EVENT_MASK) || (a == OFS_OSC_CAL_TIMEOUT) ||
         (a == OFS_SELFTEST_CONFIG) || (a == OFS_LOCK_KEY);
   endfunction

   function automatic logic [23:0] phase_limit(input int idx,
      input logic [15:0] osc_us);
      case (idx)
         0: phase_limit = 24'(BIAS_LIMIT_US);
         1: phase_limit = 24'(CONFIG_LIMIT_US);
         2: phase_limit = 24'(PLL_LIMIT_US);
         default: phase_limit = {8'h00, osc_us};
      endcase
   endfunction

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign ring_osc_select = fallback_reg;
   assign config_write_locked = locked_reg;
   assign irq = irq_reg;

   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign do_read = s_axi_arvalid && arready_reg;
   assign wr_resp = is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;

   // write address and data capture, either order
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         waddr_reg <= 6'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && awready_reg)
         begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            waddr_reg <= {s_axi_awaddr[5:2], 2'b00};
         end
         if (s_axi_wvalid && wready_reg)
         begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_resp;
         end
         else if (bvalid_reg && s_axi_bready)
         begin
            bvalid_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // read data mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'b00})
         OFS_DEVICE_STATUS: rd_word = status_reg;
         OFS_EVENT_STATUS: rd_word = {24'h000000, event_reg};
         OFS_EVENT_MASK: rd_word = {24'h000000, mask_reg};
         OFS_OSC_CAL_TIMEOUT: rd_word = {16'h0000, osc_cal_reg};
         OFS_SELFTEST_CONFIG: rd_word = {30'h0000_0000, selftest_cfg_reg};
         OFS_LOCK_KEY: rd_word = {31'h0000_0000, locked_reg};
         default: rd_resp = RESP_SLVERR;
      endcase
   end

   // read channel
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end
      else if (do_read)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_resp;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // lock key and config registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         locked_reg <= 1'b0;
         osc_cal_reg <= OSC_CAL_TIMEOUT_RESET;
         selftest_cfg_reg <= SELFTEST_CONFIG_RESET;
         mask_reg <= EVENT_MASK_RESET;
      end
      else if (do_write)
      begin
         if (waddr_reg == OFS_LOCK_KEY && wstrb_reg[1:0] == 2'b11)
         begin
            if (wdata_reg[15:0] == LOCK_KEY_SET)
               locked_reg <= 1'b1;
            else if (wdata_reg[15:0] == LOCK_KEY_CLEAR)
               locked_reg <= 1'b0;
         end
         if (waddr_reg == OFS_EVENT_MASK && wstrb_reg[0])
            mask_reg <= wdata_reg[EV_WIDTH-1:0];
         if (!locked_reg)
         begin
            if (waddr_reg == OFS_OSC_CAL_TIMEOUT)
            begin
               if (wstrb_reg[0])
                  osc_cal_reg[7:0] <= wdata_reg[7:0];
               if (wstrb_reg[1])
                  osc_cal_reg[15:8] <= wdata_reg[15:8];
            end
            if (waddr_reg == OFS_SELFTEST_CONFIG && wstrb_reg[0])
               selftest_cfg_reg <= wdata_reg[1:0];
         end
      end
   end

   // microsecond tick
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         us_div_reg <= 7'h00;
         us_tick_reg <= 1'b0;
      end
      else if (us_div_reg == 7'(CYCLES_PER_US - 1))
      begin
         us_div_reg <= 7'h00;
         us_tick_reg <= 1'b1;
      end
      else
      begin
         us_div_reg <= us_div_reg + 7'h01;
         us_tick_reg <= 1'b0;
      end
   end

   // startup phase timeout timers
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         timeout_pulse[i] = timer_run_reg[i] && us_tick_reg &&
            !phase_start[i] && !phase_done[i] &&
            (timer_cnt_reg[i] + 24'h000001 >= phase_limit(i, osc_cal_reg));
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_run_reg <= 4'h0;
         for (int i = 0; i < 4; i++)
            timer_cnt_reg[i] <= 24'h000000;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (phase_start[i])
            begin
               timer_run_reg[i] <= 1'b1;
               timer_cnt_reg[i] <= 24'h000000;
            end
            else if (phase_done[i] || timeout_pulse[i])
               timer_run_reg[i] <= 1'b0;
            else if (timer_run_reg[i] && us_tick_reg)
               timer_cnt_reg[i] <= timer_cnt_reg[i] + 24'h000001;
         end
      end
   end

   // divider toggle synchroniser and edge detect
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         toggle_s1_reg <= 1'b0;
         toggle_s2_reg <= 1'b0;
         toggle_s3_reg <= 1'b0;
      end
      else
      begin
         toggle_s1_reg <= sysdiv_toggle;
         toggle_s2_reg <= toggle_s1_reg;
         toggle_s3_reg <= toggle_s2_reg;
      end
   end

   // fallback to ring oscillator
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fallback_cnt_reg <= 16'h0000;
         toggle_seen_reg <= 1'b0;
         fallback_reg <= 1'b0;
      end
      else if (!toggle_seen_reg && !fallback_reg)
      begin
         // no edge until the chain holds real samples
         if (toggle_s2_reg != toggle_s3_reg &&
            fallback_cnt_reg >= 16'(SYNC_FILL_CYCLES))
            toggle_seen_reg <= 1'b1;
         else if (fallback_cnt_reg == 16'(FALLBACK_WAIT_CYCLES - 1))
            fallback_reg <= 1'b1;
         else
            fallback_cnt_reg <= fallback_cnt_reg + 16'h0001;
      end
   end

   // common config marker
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         common_done_reg <= 1'b0;
      else if (common_config_done)
         common_done_reg <= 1'b1;
   end

   // status word, read-only to software
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         status_reg <= DEVICE_STATUS_RESET;
      else
      begin
         if (logic_selftest_done)
            status_reg[POS_LOGIC_SELFTEST] <= 1'b1;
         if (boot_sequence_done)
            status_reg[POS_BOOT_COMPLETE] <= 1'b1;
         for (int i = 0; i < 4; i++)
            if (timeout_pulse[i])
               status_reg[POS_TIMEOUT_LSB + i] <= 1'b1;
         status_reg[POS_ENGINE1] <= spread_engine1_active;
         status_reg[POS_ENGINE0] <= spread_engine0_active;
         if (analog_selftest_done && selftest_cfg_reg[POS_ANALOG_EN])
            status_reg[POS_ANALOG_SELFTEST] <= 1'b1;
         if (digital_selftest_done && selftest_cfg_reg[POS_DIGITAL_EN])
            status_reg[POS_DIGITAL_SELFTEST] <= 1'b1;
         status_reg[POS_BACKUP_OSC] <= fallback_reg;
         status_reg[POS_CRYSTAL] <= crystal_select;
         if (config_load_done)
         begin
            status_reg[POS_CONFIG_LOAD] <= 1'b1;
            status_reg[POS_SINGLE_ENDED] <= single_ended_detect;
         end
         status_reg[POS_WRITE_LOCKED] <= locked_reg;
         if (user_config_done && common_done_reg)
         begin
            status_reg[POS_USER_VALID] <= user_config_ok;
            status_reg[3:0] <= user_config_index;
         end
      end
   end

   // sticky events, write one to clear, set wins
   always_comb
   begin
      ev_set = '0;
      ev_set[EV_BOOT] = boot_sequence_done;
      ev_set[EV_TIMEOUT_LSB +: 4] = timeout_pulse;
      ev_set[EV_BACKUP_OSC] = fallback_reg && !status_reg[POS_BACKUP_OSC];
      ev_set[EV_CONFIG_LOAD] = config_load_done;
      ev_set[EV_LOGIC_SELFTEST] = logic_selftest_done;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         event_reg <= '0;
      else if (do_write && waddr_reg == OFS_EVENT_STATUS && wstrb_reg[0])
         event_reg <= (event_reg & ~wdata_reg[EV_WIDTH-1:0]) | ev_set;
      else
         event_reg <= event_reg | ev_set;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(event_reg & mask_reg);
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence write_pair;
      aw_held_reg && w_held_reg && !bvalid_reg;
   endsequence

   sequence read_take;
      s_axi_arvalid && arready_reg;
   endsequence

   a_logic_selftest: assert property (
      logic_selftest_done |=> status_reg[POS_LOGIC_SELFTEST])
      else $error("logic self test bit not set");
   a_boot_done: assert property (
      !boot_sequence_done && !status_reg[POS_BOOT_COMPLETE]
      |=> !status_reg[POS_BOOT_COMPLETE])
      else $error("boot bit set without boot done");
   a_timeout_flag: assert property (
      timeout_pulse[0] |=> status_reg[POS_TIMEOUT_LSB] && !timer_run_reg[0])
      else $error("bias timeout not flagged");
   a_engine_follow: assert property (
      $rose(spread_engine1_active) |=> status_reg[POS_ENGINE1])
      else $error("engine 1 status does not follow");
   a_analog_gate: assert property (
      analog_selftest_done && !selftest_cfg_reg[POS_ANALOG_EN] &&
      !status_reg[POS_ANALOG_SELFTEST] |=> !status_reg[POS_ANALOG_SELFTEST])
      else $error("analog bit set while disabled");
   a_fallback_set: assert property (
      !toggle_seen_reg && !fallback_reg && toggle_s2_reg == toggle_s3_reg &&
      fallback_cnt_reg == 16'(FALLBACK_WAIT_CYCLES - 1)
      |=> ring_osc_select ##1 status_reg[POS_BACKUP_OSC])
      else $error("fallback not taken");
   a_locked_ignore: assert property (
      do_write && locked_reg && waddr_reg == OFS_OSC_CAL_TIMEOUT
      |=> $stable(osc_cal_reg))
      else $error("config write taken while locked");
   a_user_order: assert property (
      user_config_done && !common_done_reg |=> $stable(status_reg[4:0]))
      else $error("user config taken before common");
   a_reserved_zero: assert property (
      status_reg[31:20] == 12'h000)
      else $error("reserved status bits not zero");
   a_write_answer: assert property (
      write_pair |=> s_axi_bvalid && s_axi_bresp == $past(wr_resp))
      else $error("write response missing");
   a_read_answer: assert property (
      read_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data missing");
   a_irq_level: assert property (
      |(event_reg & mask_reg) |=> irq)
      else $error("interrupt not raised");

endmodule

/* bench/test_device_startup_status.sv */
// self-checking bench for the startup status register block
`timescale 1ns/100ps
module test_device_startup_status import startup_status_pkg::*;;
   logic sys_clk, rst_n, div_run;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, phase_start, phase_done, user_config_index;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, logic_selftest_done;
   logic boot_sequence_done, analog_selftest_done, digital_selftest_done;
   logic sysdiv_toggle, spread_engine0_active, spread_engine1_active;
   logic crystal_select, common_config_done, config_load_done;
   logic single_ended_detect, user_config_done, user_config_ok;
   logic ring_osc_select, config_write_locked, irq;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   int n_fail, checked, cyc;

   device_startup_status #(.BIAS_LIMIT_US(3), .CONFIG_LIMIT_US(3),
      .PLL_LIMIT_US(3)) device_startup_status_inst (.sys_clk, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .logic_selftest_done, .boot_sequence_done,
      .phase_start, .phase_done, .analog_selftest_done,
      .digital_selftest_done, .sysdiv_toggle, .spread_engine0_active,
      .spread_engine1_active, .crystal_select, .common_config_done,
      .config_load_done, .single_ended_detect, .user_config_done,
      .user_config_ok, .user_config_index, .ring_osc_select,
      .config_write_locked, .irq);

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [33:0] g, input logic [33:0] x);
      checked++;
      if (g !== x)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d,
      input logic [1:0] r = RESP_OKAY);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge sys_clk);
         if (!ad && s_axi_awready === 1'b1)
         begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1)
         begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      chk({32'h0, s_axi_bresp}, {32'h0, r});
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] d,
      input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      tick(6);
      rst_n <= 1'b1;
      tick(1);
   endtask

   // read monitor: oldest note against each read answer
   always @(posedge sys_clk)
   begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      begin
         e = exp_q.pop_front();
         chk({s_axi_rresp, s_axi_rdata}, e);
      end
   end

   // divider activity and run limit
   always @(posedge sys_clk)
   begin
      if (div_run)
         sysdiv_toggle <= ~sysdiv_toggle;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   initial
   begin
      logic [31:0] full;
      logic [3:0] idx;
      logic [15:0] v;
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, logic_selftest_done} = '0;
      {boot_sequence_done, analog_selftest_done} = '0;
      {digital_selftest_done, spread_engine0_active} = '0;
      {spread_engine1_active, crystal_select, common_config_done} = '0;
      {config_load_done, single_ended_detect, user_config_done} = '0;
      {user_config_ok, phase_start, phase_done, user_config_index} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      sysdiv_toggle = 1'b0;
      div_run = 1'b1;
      {n_fail, checked, cyc} = '0;
      void'($urandom(32'h75DB));
      idx = 4'($urandom_range(15, 1));
      v = 16'($urandom_range(16'hFFFF, 16'h0010));
      do_reset();
      rd(OFS_DEVICE_STATUS, DEVICE_STATUS_RESET);
      rd(OFS_OSC_CAL_TIMEOUT, {16'h0, OSC_CAL_TIMEOUT_RESET});
      rd(6'h18, 32'h0, RESP_SLVERR);
      wr(6'h18, 32'h0, RESP_SLVERR);
      wr(OFS_DEVICE_STATUS, 32'hFFFF_FFFF);
      // user load before common load, analog test while disabled
      user_config_done <= 1'b1;
      user_config_ok <= 1'b1;
      user_config_index <= 4'h5;
      analog_selftest_done <= 1'b1;
      tick(1);
      {user_config_done, analog_selftest_done} <= '0;
      tick(2);
      rd(OFS_DEVICE_STATUS, 32'h0);
      wr(OFS_SELFTEST_CONFIG, 32'h3);
      wr(OFS_OSC_CAL_TIMEOUT, 32'h2);
      spread_engine0_active <= 1'b1;
      spread_engine1_active <= 1'b1;
      crystal_select <= 1'b1;
      {logic_selftest_done, boot_sequence_done} <= 2'h3;
      {analog_selftest_done, digital_selftest_done} <= 2'h3;
      common_config_done <= 1'b1;
      tick(1);
      {logic_selftest_done, boot_sequence_done} <= '0;
      {analog_selftest_done, digital_selftest_done} <= '0;
      common_config_done <= 1'b0;
      config_load_done <= 1'b1;
      single_ended_detect <= 1'b1;
      tick(1);
      config_load_done <= 1'b0;
      user_config_done <= 1'b1;
      user_config_index <= idx;
      tick(1);
      user_config_done <= 1'b0;
      // all four timers start, config load finishes in time
      phase_start <= 4'hF;
      tick(1);
      phase_start <= 4'h0;
      tick(10);
      phase_done <= 4'h2;
      tick(1);
      phase_done <= 4'h0;
      tick(500);
      full = (32'h1 << POS_LOGIC_SELFTEST) | (32'h1 << POS_BOOT_COMPLETE);
      full |= (32'hD << POS_TIMEOUT_LSB) | (32'h3 << POS_ENGINE0);
      full |= (32'h3 << POS_DIGITAL_SELFTEST) | (32'h1 << POS_CRYSTAL);
      full |= (32'h1 << POS_CONFIG_LOAD) | (32'h1 << POS_SINGLE_ENDED);
      full |= (32'h1 << POS_USER_VALID) | {28'h0, idx};
      rd(OFS_DEVICE_STATUS, full);
      rd(OFS_EVENT_STATUS, 32'hDB);
      chk({33'h0, irq}, 34'h0);
      wr(OFS_EVENT_MASK, 32'h80);
      tick(2);
      chk({33'h0, irq}, 34'h1);
      wr(OFS_EVENT_STATUS, 32'hFF);
      tick(2);
      chk({33'h0, irq}, 34'h0);
      rd(OFS_EVENT_STATUS, 32'h0);
      // lock, try config writes, unlock
      wr(OFS_LOCK_KEY, {16'h0, LOCK_KEY_SET});
      tick(2);
      chk({33'h0, config_write_locked}, 34'h1);
      rd(OFS_DEVICE_STATUS, full | (32'h1 << POS_WRITE_LOCKED));
      wr(OFS_OSC_CAL_TIMEOUT, {16'h0, v});
      rd(OFS_OSC_CAL_TIMEOUT, 32'h2);
      wr(OFS_EVENT_MASK, 32'h01);
      rd(OFS_EVENT_MASK, 32'h01);
      rd(OFS_LOCK_KEY, 32'h1);
      wr(OFS_LOCK_KEY, {16'h0, LOCK_KEY_CLEAR});
      tick(2);
      rd(OFS_DEVICE_STATUS, full);
      // silent divider after a fresh reset
      div_run <= 1'b0;
      {spread_engine0_active, spread_engine1_active} <= '0;
      crystal_select <= 1'b0;
      do_reset();
      tick(1100);
      chk({33'h0, ring_osc_select}, 34'h1);
      rd(OFS_DEVICE_STATUS, 32'h1 << POS_BACKUP_OSC);
      rd(OFS_EVENT_STATUS, 32'h1 << EV_BACKUP_OSC);
      tick(2);
      end_sim();
   end
endmodule
